// >>> src/spz_pkg.sv
package spz_pkg;

  // Register offsets are printed as indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'h98;
  localparam logic [7:0] IDX_BUFFER    = 8'h99;
  localparam logic [7:0] IDX_AUX       = 8'hA0;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hA1;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hA2;
  localparam logic [7:0] IDX_RELOAD1   = 8'hA3;
  localparam logic [7:0] IDX_RELOAD2   = 8'hA4;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET  = 8'h00;

  // Control field positions
  localparam int BIT_MODE_HIGH = 7;
  localparam int BIT_MODE_LOW  = 6;
  localparam int BIT_MPSEL     = 5;
  localparam int BIT_RXEN      = 4;
  localparam int BIT_TX9       = 3;
  localparam int BIT_RX9       = 2;
  localparam int BIT_TXDONE    = 1;
  localparam int BIT_RXDONE    = 0;

  // Aux register: bit0 double rate, bit1 timer2 select, bit2 port interrupt enable
  localparam int BIT_DOUBLE    = 0;
  localparam int BIT_T2SEL     = 1;
  localparam int BIT_IE        = 2;

  // Interrupt status/mask bits
  localparam int IRQ_RX        = 0;
  localparam int IRQ_TX        = 1;

  // Bit periods in peripheral clocks
  localparam logic [15:0] SYNC_SLOW   = 16'h000C;
  localparam logic [15:0] SYNC_FAST   = 16'h0004;
  localparam logic [15:0] FIXED_SLOW  = 16'h0040;
  localparam logic [15:0] FIXED_FAST  = 16'h0020;
  localparam logic [15:0] RELOAD_RST  = 16'h0010;

  localparam logic [3:0] SYNC_BITS    = 4'h8;

  typedef struct packed {
    logic       mode_select_high;
    logic       mode_select_low;
    logic       multiprocessor_select;
    logic       receive_enable;
    logic       transmit_ninth_bit;
    logic       receive_ninth_bit;
    logic       transmit_complete_flag;
    logic       receive_complete_flag;
  } spz_control_t;

  typedef struct packed {
    logic       txd;
    logic       rxd_out;
    logic       rxd_oe;
  } spz_pins_t;

endpackage : spz_pkg

// >>> src/spz_rate.sv
`timescale 1ns/1ps
// Bit-period tick generator: free count down from a selected period
module spz_rate (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        restart_i,
  input  wire logic [15:0] period_i,
  output logic             tick_o
);
  logic [15:0] count;
  wire  logic  at_end = (count <= 16'h0001);

  assign tick_o = at_end & ~restart_i;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 16'h0001;
    end else if (restart_i || at_end) begin
      count <= period_i;
    end else begin
      count <= count - 16'h0001;
    end
  end
endmodule : spz_rate

// >>> src/spz_serial.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////
module spz_serial (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             irq_o
);

  //////////////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} spz_state_t;

  spz_pkg::spz_control_t ctl;
  logic [7:0]            tx_buf;
  logic [7:0]            rx_buf;
  logic [2:0]            aux;
  logic [1:0]            irq_stat;
  logic [1:0]            irq_mask;
  logic [15:0]           reload1;
  logic [15:0]           reload2;

  spz_state_t            tx_st;
  spz_state_t            rx_st;
  logic [8:0]            tx_sh;
  logic [3:0]            tx_cnt;
  logic [7:0]            rx_sh;
  logic [3:0]            rx_cnt;
  logic                  rx_prev;
  logic                  sync_clk;
  logic                  sync_phase;
  logic                  txd_q;
  logic                  rx_was_en;

  //////////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire  logic       acc        = psel_i & penable_i;
  wire  logic [9:0] idx        = paddr_i[11:2];
  wire  logic       wr         = acc & pwrite_i & pstrb_i[0];
  wire  logic       hit_ctl    = (idx == {2'b00, spz_pkg::IDX_CONTROL});
  wire  logic       hit_buf    = (idx == {2'b00, spz_pkg::IDX_BUFFER});
  wire  logic       hit_aux    = (idx == {2'b00, spz_pkg::IDX_AUX});
  wire  logic       hit_ist    = (idx == {2'b00, spz_pkg::IDX_IRQ_STAT});
  wire  logic       hit_imsk   = (idx == {2'b00, spz_pkg::IDX_IRQ_MASK});
  wire  logic       hit_rl1    = (idx == {2'b00, spz_pkg::IDX_RELOAD1});
  wire  logic       hit_rl2    = (idx == {2'b00, spz_pkg::IDX_RELOAD2});
  wire  logic       mapped     = hit_ctl | hit_buf | hit_aux | hit_ist | hit_imsk
                                 | hit_rl1 | hit_rl2;
  wire  logic       wr_ctl     = wr & hit_ctl;
  wire  logic       wr_buf     = wr & hit_buf;
  wire  logic [1:0] mode       = {ctl.mode_select_high, ctl.mode_select_low};
  wire  logic       mode0      = (mode == 2'b00);
  wire  logic       ninth_mode = ctl.mode_select_high;

  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  //////////////////////////////////////////////////////////////////////////////////////
  // Bit period select
  logic [15:0] period;
  wire  logic  use_t2 = aux[spz_pkg::BIT_T2SEL] & ~(mode == 2'b01 & ctl.multiprocessor_select);
  always_comb begin
    case (mode)
      2'b00:   period = ctl.multiprocessor_select ? spz_pkg::SYNC_FAST
                                                  : spz_pkg::SYNC_SLOW;
      2'b10:   period = aux[spz_pkg::BIT_DOUBLE] ? spz_pkg::FIXED_FAST
                                                 : spz_pkg::FIXED_SLOW;
      default: period = use_t2 ? reload2 : reload1;
    endcase
  end

  // Mode 0 runs two half-period phases per bit
  wire  logic [15:0] half_period = (period >> 1);
  logic              tx_tick;
  logic              rx_tick;
  wire  logic        tx_go  = wr_buf & (tx_st == ST_IDLE);
  wire  logic        rx_edge = rx_prev & ~rxd_i;
  wire  logic        m0_rx_go = mode0 & ctl.receive_enable & ~rx_was_en
                                & (rx_st == ST_IDLE) & (tx_st == ST_IDLE);
  wire  logic        rx_go  = ~mode0 & ctl.receive_enable & rx_edge & (rx_st == ST_IDLE);

  spz_rate u_tx_rate (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .restart_i (tx_go | m0_rx_go),
    .period_i  (mode0 ? half_period : period),
    .tick_o    (tx_tick)
  );

  // Receiver samples mid-bit: restart loads half period first
  logic [15:0] rx_period;
  assign rx_period = (rx_st == ST_IDLE) ? half_period : period;
  spz_rate u_rx_rate (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .restart_i (rx_go),
    .period_i  (rx_period),
    .tick_o    (rx_tick)
  );

  //////////////////////////////////////////////////////////////////////////////////////
  // Transmit and mode 0 shifter
  logic set_tx;
  logic set_rx;
  logic rx9_val;
  logic rx9_load;
  wire  logic m0_busy = mode0 & (tx_st != ST_IDLE);
  wire  logic m0_rx   = m0_busy & ~tx_sh[8];
  wire  logic m0_rise = m0_busy & tx_tick & ~sync_phase;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st      <= ST_IDLE;
      tx_sh      <= 9'h1FF;
      tx_cnt     <= 4'h0;
      txd_q      <= 1'b1;
      sync_clk   <= 1'b1;
      sync_phase <= 1'b0;
      rx_sh      <= 8'h00;
    end else if (tx_go | m0_rx_go) begin
      tx_st      <= mode0 ? ST_DATA : ST_START;
      // Bit 8 marks a mode 0 transmit versus receive
      tx_sh      <= {~m0_rx_go, tx_go ? pwdata_i[7:0] : tx_buf};
      tx_cnt     <= 4'h0;
      txd_q      <= mode0 ? 1'b1 : 1'b0;
      sync_phase <= 1'b0;
    end else if (tx_tick) begin
      case (tx_st)
        ST_START: begin
          tx_st <= ST_DATA;
          txd_q <= tx_sh[0];
        end
        ST_DATA: begin
          if (mode0) begin
            sync_clk   <= sync_phase;
            sync_phase <= ~sync_phase;
            if (sync_phase) begin
              tx_cnt <= tx_cnt + 4'h1;
              tx_sh  <= {tx_sh[8], 1'b1, tx_sh[7:1]};
              if (m0_rx) rx_sh <= {rxd_i, rx_sh[7:1]};                  // Sampled on rising clock
              if (tx_cnt == spz_pkg::SYNC_BITS - 4'h1) begin
                tx_st <= ST_IDLE;
              end
            end
          end else if (tx_cnt == 4'h7) begin
            tx_st <= ninth_mode ? ST_NINTH : ST_STOP;
            txd_q <= ninth_mode ? ctl.transmit_ninth_bit : 1'b1;
          end else begin
            tx_cnt <= tx_cnt + 4'h1;
            tx_sh  <= {tx_sh[8], 1'b1, tx_sh[7:1]};
            txd_q  <= tx_sh[1];
          end
        end
        ST_NINTH: begin
          tx_st <= ST_STOP;
          txd_q <= 1'b1;
        end
        ST_STOP:  tx_st <= ST_IDLE;
        default:  tx_st <= ST_IDLE;
      endcase
    end
  end

  // Flag at end of last data bit (8th in mode 0, 9th with ninth bit)
  wire logic tx_last = tx_tick & ((tx_st == ST_DATA & mode0 & sync_phase
                                   & tx_cnt == spz_pkg::SYNC_BITS - 4'h1)
                                  | (tx_st == ST_DATA & ~mode0 & tx_cnt == 4'h7 & ~ninth_mode)
                                  | (tx_st == ST_NINTH));
  wire logic m0_rx_done = tx_last & mode0 & ~tx_sh[8];
  wire logic m0_tx_done = tx_last & mode0 & tx_sh[8];

  //////////////////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver
  logic rx_ok;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st      <= ST_IDLE;
      rx_cnt     <= 4'h0;
      rx_prev    <= 1'b1;
      rx_was_en  <= 1'b0;
    end else begin
      rx_prev   <= rxd_i;
      rx_was_en <= ctl.receive_enable;
      if (!ctl.receive_enable || mode0) begin
        rx_st <= ST_IDLE;
      end else if (rx_go) begin
        rx_st  <= ST_START;
        rx_cnt <= 4'h0;
      end else if (rx_tick) begin
        case (rx_st)
          // False start bit is dropped
          ST_START: rx_st <= rxd_i ? ST_IDLE : ST_DATA;
          ST_DATA: begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == 4'h7) begin
              rx_st <= ninth_mode ? ST_NINTH : ST_STOP;
            end
          end
          ST_NINTH: rx_st <= ST_STOP;
          ST_STOP:  rx_st <= ST_IDLE;
          default:  rx_st <= ST_IDLE;
        endcase
      end
    end
  end

  logic [7:0] rx_data;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_data <= 8'h00;
    end else if (rx_tick && rx_st == ST_DATA) begin
      rx_data <= {rxd_i, rx_data[7:1]};
    end
  end

  // Ninth-bit modes finish on the ninth sample, mode 1 on the stop sample
  wire logic rx_end9 = rx_tick & (rx_st == ST_NINTH) & ctl.receive_enable & ~mode0;
  wire logic rx_end1 = rx_tick & (rx_st == ST_STOP) & ~ninth_mode & ctl.receive_enable & ~mode0;
  always_comb begin
    rx_ok    = 1'b0;
    rx9_val  = rxd_i;
    rx9_load = 1'b0;
    if (rx_end9) begin
      rx9_load = 1'b1;
      rx_ok    = ~ctl.multiprocessor_select | rxd_i;
    end else if (rx_end1) begin
      rx9_load = ~ctl.multiprocessor_select;
      rx_ok    = ~ctl.multiprocessor_select | rxd_i;
    end
  end
  assign set_rx = (rx_ok & ~ctl.receive_complete_flag) | m0_rx_done;
  assign set_tx = m0_tx_done | (tx_last & ~mode0);

  //////////////////////////////////////////////////////////////////////////////////////
  // Registers
  wire logic [7:0] wctl = pwdata_i[7:0];
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl <= spz_pkg::CONTROL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl <= wctl;
      end
      if (rx9_load && set_rx) begin
        ctl.receive_ninth_bit <= rx9_val;
      end
      // Hardware set wins over a software clear in the same cycle
      if (set_tx) begin
        ctl.transmit_complete_flag <= 1'b1;
      end
      if (set_rx) begin
        ctl.receive_complete_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_buf   <= spz_pkg::BUFFER_RESET;
      rx_buf   <= spz_pkg::BUFFER_RESET;
      aux      <= 3'h0;
      irq_mask <= 2'h0;
      reload1  <= spz_pkg::RELOAD_RST;
      reload2  <= spz_pkg::RELOAD_RST;
    end else begin
      if (wr_buf) tx_buf <= pwdata_i[7:0];
      if (set_rx) rx_buf <= mode0 ? {rxd_i, rx_sh[7:1]} : rx_data;
      if (wr & hit_aux) aux <= pwdata_i[2:0];
      if (wr & hit_imsk) irq_mask <= pwdata_i[1:0];
      if (wr & hit_rl1) reload1 <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 : pwdata_i[15:0];
      if (wr & hit_rl2) reload2 <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 : pwdata_i[15:0];
    end
  end

  // Sticky status, write one to clear; set wins
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr & hit_ist) ? pwdata_i[1:0] : 2'h0)) | {set_tx, set_rx};
    end
  end

  wire logic port_irq = aux[spz_pkg::BIT_IE]
                        & (ctl.receive_complete_flag | ctl.transmit_complete_flag);
  assign irq_o = port_irq | |(irq_stat & irq_mask);

  //////////////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= hit_ctl  ? {24'h00_0000, ctl}          :
                  hit_buf  ? {24'h00_0000, rx_buf}       :
                  hit_aux  ? {29'h0000_0000, aux}        :
                  hit_ist  ? {30'h0000_0000, irq_stat}   :
                  hit_imsk ? {30'h0000_0000, irq_mask}   :
                  hit_rl1  ? {16'h0000, reload1}         :
                  hit_rl2  ? {16'h0000, reload2}         : 32'h0000_0000;
    end
  end

  // Pins: mode 0 drives clock on tx and data on rx when sending
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txd_o    <= 1'b1;
      rxd_o    <= 1'b1;
      rxd_oe_o <= 1'b0;
    end else begin
      txd_o    <= m0_busy ? sync_clk : txd_q;
      rxd_o    <= tx_sh[0];
      rxd_oe_o <= m0_busy & tx_sh[8];
    end
  end

endmodule : spz_serial

// >>> testbench/spz_peer.sv
`timescale 1ns/1ps
module spz_peer (
  input  wire logic        sys_clk_i,
  input  wire logic        txd_i,
  input  wire logic        line_i,
  input  wire logic        m0_i,
  input  wire logic [15:0] per_i,
  input  wire logic [3:0]  nb_i,
  output logic             rxd_o
);
  logic [9:0] got[$];
  logic [7:0] m0q[$];
  logic [7:0] m0_byte = 8'h00;
  logic [7:0] sh      = 8'h00;
  int         cnt     = 0;
  initial rxd_o = 1'b1;
  // Async receive, mid-bit samples, stop bit kept on top
  always begin : rx_async
    logic [9:0] w;
    @(negedge txd_i);
    if (!m0_i) begin
      w = '0;
      repeat (per_i / 2) @(posedge sys_clk_i);
      for (int i = 0; i <= nb_i; i++) begin
        repeat (per_i) @(posedge sys_clk_i);
        w[i] = txd_i;
      end
      // Hand over only once the stop bit is over, so a new write is not refused
      repeat (per_i / 2) @(posedge sys_clk_i);
      got.push_back(w);
    end
  end
  // Shift register: device data mid-bit at falling, ours changes at falling
  always @(negedge txd_i) begin
    if (m0_i) begin
      sh = {line_i, sh[7:1]};
      rxd_o <= m0_byte[cnt];
      cnt++;
      if (cnt == 8) begin
        m0q.push_back(sh);
        cnt = 0;
      end
    end
  end
  // Released line must not keep the last bit
  always @(posedge txd_i) begin
    if (m0_i && cnt == 0) begin
      repeat (2) @(posedge sys_clk_i);
      rxd_o <= ~rxd_o;
    end
  end
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    for (int i = 0; i <= nb + 1; i++) begin
      rxd_o <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i - 1];
      repeat (per_i) @(posedge sys_clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send
endmodule : spz_peer

// >>> testbench/spz_serial_asserts.sv
`timescale 1ns/1ps
module spz_serial_asserts (
  input wire logic        sys_clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_o,
  input wire logic        irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [7:0]  ctl;
  logic        dbl, last_q;
  logic [15:0] run;
  wire  [9:0]  idx    = paddr_i[11:2];
  wire         al     = paddr_i[1:0] == 2'b00;
  wire         mapped = idx == spz_pkg::IDX_CONTROL || idx == spz_pkg::IDX_BUFFER
                        || (idx >= spz_pkg::IDX_AUX && idx <= spz_pkg::IDX_RELOAD2);
  wire         wr_ok  = psel_i & penable_i & pwrite_i & pstrb_i[0] & al;
  wire         wr_ctl = wr_ok & (idx == spz_pkg::IDX_CONTROL);
  wire         wr_buf = wr_ok & (idx == spz_pkg::IDX_BUFFER);
  wire         wr_aux = wr_ok & (idx == spz_pkg::IDX_AUX);
  wire  [15:0] per2   = dbl ? spz_pkg::FIXED_FAST : spz_pkg::FIXED_SLOW;
  wire  [15:0] half0  = (ctl[5] ? spz_pkg::SYNC_FAST : spz_pkg::SYNC_SLOW) >> 1;
  wire         async  = ctl[7:6] != 2'b00;
  wire         mode2  = ctl[7:6] == 2'b10;
  // Mirror of software mode bits; flags are ignored
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl <= 8'h00;
      dbl <= 1'b0;
    end else begin
      if (wr_ctl) ctl <= pwdata_i[7:0];
      if (wr_aux) dbl <= pwdata_i[spz_pkg::BIT_DOUBLE];
    end
  end
  // Length of the current line level, so a pulse can be judged when it ends
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= 1'b1;
      run    <= 16'h0000;
    end else begin
      last_q <= txd_o;
      run    <= (txd_o != last_q) ? 16'h0001 : run + 16'h0001;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  chk_oe_async: assert property (async |-> !rxd_oe_o)
    else $error("data pin driven in async mode");
  chk_m0_clock: assert property (!async && $rose(txd_o) |-> run == half0)
    else $error("mode 0 clock low half wrong");
  chk_m2_bit: assert property (mode2 && $rose(txd_o) |-> run % per2 == 16'h0000)
    else $error("mode 2 bit period wrong");
  chk_m2_len: assert property (mode2 && $rose(txd_o) |-> run <= 16'd10 * per2)
    else $error("mode 2 low run too long");
  chk_m0_rx_start: assert property (wr_ctl && pwdata_i[7:6] == 2'b00 && pwdata_i[4] && !ctl[4]
    |-> ##[1:20] !txd_o)
    else $error("mode 0 receive did not start");
  chk_m0_tx_drive: assert property (wr_buf && !async && !rxd_oe_o |-> ##[1:20] rxd_oe_o)
    else $error("mode 0 transmit did not drive data");
  chk_async_start: assert property (wr_buf && async && txd_o |-> ##[1:70] !txd_o)
    else $error("start bit missing");
  chk_ready_high: assert property (psel_i |-> pready_o)
    else $error("ready low");
  chk_unmapped_err: assert property (psel_i && al |-> pslverr_o == (penable_i && !mapped))
    else $error("error response wrong");
  cover property (mode2 && $rose(txd_o));
  cover property (wr_ctl && pwdata_i[4] && pwdata_i[7:6] == 2'b00);
  cover property (psel_i && pslverr_o);
endmodule : spz_serial_asserts

bind spz_serial spz_serial_asserts i_chk (.sys_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .rxd_i, .txd_o, .rxd_o,
  .rxd_oe_o, .irq_o);

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  logic        sys_clk_i, arst_n_i, psel, penable, pwrite, m0, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  pstrb, nb;
  logic [15:0] per;
  logic [9:0]  w;
  logic [7:0]  d, e;
  wire         pready, pslverr, txd, rxd_o, rxd_oe, irq, peer_rxd;
  wire  [31:0] prdata;
  wire         rxd_w = rxd_oe ? rxd_o : peer_rxd;
  int          compares = 0, n_mismatch = 0, cyc = 0, n;
  spz_serial i_dut (.sys_clk_i, .arst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .rxd_i(rxd_w), .txd_o(txd), .rxd_o, .rxd_oe_o(rxd_oe), .irq_o(irq));
  spz_peer i_peer (.sys_clk_i, .txd_i(txd), .line_i(rxd_w), .m0_i(m0), .per_i(per), .nb_i(nb),
    .rxd_o(peer_rxd));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic we, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin @(posedge sys_clk_i); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 4'hF);
  endtask : wr
  task automatic rdx(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0000_0000, 4'hF);
  endtask : rdx
  task automatic wait_for(input bit on_irq);
    n = 0;
    while ((on_irq ? irq !== 1'b1 : i_peer.got.size() + i_peer.m0q.size() == 0) && n < 3000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 3000) n_mismatch++;
  endtask : wait_for
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_i, psel, penable, pwrite, m0, paddr, pwdata, pstrb} = '0;
    per = spz_pkg::FIXED_SLOW;
    nb = 4'h9;
    void'($urandom(43841));
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_0000)
    rdx(spz_pkg::IDX_BUFFER);
    `CHK(rd, 32'h0000_0000)
    rdx(spz_pkg::IDX_RELOAD1);
    `CHK(rd, {16'h0000, spz_pkg::RELOAD_RST})
    rdx(8'h9A);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, spz_pkg::IDX_CONTROL, 32'h0000_00C0, 4'hE);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_0000)
    $display("test registers done");
    // Mode 2: both fixed rates, both ninth-bit values
    for (int i = 0; i < 4; i++) begin
      per = i[0] ? spz_pkg::FIXED_FAST : spz_pkg::FIXED_SLOW;
      d = $urandom;
      wr(spz_pkg::IDX_AUX, 8'h04 | i[0]);
      wr(spz_pkg::IDX_CONTROL, 8'h80 | (i[1] << 3));
      wr(spz_pkg::IDX_BUFFER, d);
      wait_for(1'b0);
      w = i_peer.got.pop_front();
      `CHK(w, {1'b1, i[1], d})
      `CHK(irq, 1'b1)
      rdx(spz_pkg::IDX_CONTROL);
      `CHK(rd, 8'h82 | (i[1] << 3))
      wr(spz_pkg::IDX_CONTROL, 8'h80);
      rdx(spz_pkg::IDX_IRQ_STAT);
      `CHK(rd, 32'h0000_0002)
      `CHK(irq, 1'b0)
    end
    // Status alone drives the line when the port enable is off
    wr(spz_pkg::IDX_AUX, 8'h00);
    wr(spz_pkg::IDX_IRQ_MASK, 8'h02);
    rdx(spz_pkg::IDX_IRQ_MASK);
    `CHK(irq, 1'b1)
    wr(spz_pkg::IDX_IRQ_STAT, 8'h02);
    rdx(spz_pkg::IDX_IRQ_STAT);
    `CHK({irq, rd}, 33'h0_0000_0000)
    // Mask off again: later waits must see only the port flags
    wr(spz_pkg::IDX_IRQ_MASK, 8'h00);
    $display("test mode 2 and interrupts done");
    wr(spz_pkg::IDX_RELOAD1, 16'h0014);
    wr(spz_pkg::IDX_RELOAD2, 16'h0018);
    // Mode 1 on timer 1, mode 3 on timer 2
    for (int t = 0; t < 2; t++) begin
      per = t ? 16'h0018 : 16'h0014;
      nb = t ? 4'h9 : 4'h8;
      d = $urandom;
      wr(spz_pkg::IDX_AUX, 8'h04 | (t << 1));
      wr(spz_pkg::IDX_CONTROL, t ? 8'hC8 : 8'h40);
      wr(spz_pkg::IDX_BUFFER, d);
      wait_for(1'b0);
      w = i_peer.got.pop_front();
      `CHK(w, {t[0], 1'b1, d})
    end
    $display("test timer rates done");
    per = 16'h0014;
    d = $urandom;
    e = $urandom;
    wr(spz_pkg::IDX_AUX, 8'h04);
    wr(spz_pkg::IDX_CONTROL, 8'hF0);
    i_peer.send({1'b0, d}, 9, 1'b1);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_00F0)
    i_peer.send({1'b1, d}, 9, 1'b1);
    wait_for(1'b1);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_00F5)
    wr(spz_pkg::IDX_BUFFER, e);
    rdx(spz_pkg::IDX_BUFFER);
    `CHK(rd, {24'h00_0000, d})
    wait_for(1'b0);
    w = i_peer.got.pop_front();
    `CHK(w, {2'b10, e})
    wr(spz_pkg::IDX_CONTROL, 8'h40);
    nb = 4'h8;
    i_peer.send({1'b0, d}, 8, 1'b1);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_0040)
    wr(spz_pkg::IDX_CONTROL, 8'h70);
    i_peer.send({1'b0, e}, 8, 1'b0);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_0070)
    wr(spz_pkg::IDX_CONTROL, 8'h50);
    i_peer.send({1'b0, e}, 8, 1'b1);
    wait_for(1'b1);
    rdx(spz_pkg::IDX_CONTROL);
    `CHK(rd, 32'h0000_0055)
    rdx(spz_pkg::IDX_BUFFER);
    `CHK(rd, {24'h00_0000, e})
    $display("test async receive done");
    // Mode 0 at both shift rates, out and back in
    m0 <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      d = $urandom;
      i_peer.m0_byte = $urandom;
      wr(spz_pkg::IDX_CONTROL, f << 5);
      wr(spz_pkg::IDX_BUFFER, d);
      wait_for(1'b1);
      `CHK(i_peer.m0q.pop_front(), d)
      rdx(spz_pkg::IDX_CONTROL);
      `CHK(rd, 8'h02 | (f << 5))
      wr(spz_pkg::IDX_CONTROL, f << 5);
      wr(spz_pkg::IDX_CONTROL, 8'h10 | (f << 5));
      wait_for(1'b1);
      rdx(spz_pkg::IDX_BUFFER);
      `CHK(rd, {24'h00_0000, i_peer.m0_byte})
      wr(spz_pkg::IDX_CONTROL, f << 5);
      i_peer.m0q.delete();
    end
    $display("test mode 0 done");
    wrap_up();
  end
endmodule : testbench
